// file: shared/swk_fd_pkg.sv
// Constants and types of the FD-tolerant selective wake decoder
package swk_fd_pkg;
   // Timing, in the units printed, and derived cycle counts at 125 MHz
   localparam int unsigned CLK_MHZ      = 125;
   localparam int unsigned T_SILENCE_MS = 600;
   localparam int unsigned SILENCE_CYC  = T_SILENCE_MS * CLK_MHZ * 1000;
   localparam int unsigned T_WAKE_US    = 100;
   localparam int unsigned WAKE_CYC     = T_WAKE_US * CLK_MHZ;
   localparam int unsigned T_BIT_MIN_NS = 1000;
   localparam int unsigned BIT_MIN_CYC  = (T_BIT_MIN_NS * CLK_MHZ + 999) / 1000;
   // Frame layout, in destuffed bit indices from start-of-frame
   localparam logic [3:0]  IDLE_BITS   = 4'h8;
   localparam logic [3:0]  EOF_BITS    = 4'h7;
   localparam logic [2:0]  STUFF_RUN   = 3'h5;
   localparam logic [6:0]  IDX_RTR     = 7'h0c;
   localparam logic [6:0]  IDX_IDE     = 7'h0d;
   localparam logic [6:0]  IDX_FDF_B   = 7'h0e;
   localparam logic [6:0]  IDX_RTR_E   = 7'h20;
   localparam logic [6:0]  IDX_FDF_E   = 7'h21;
   localparam logic [6:0]  DLC_OFS     = 7'h02;
   localparam logic [6:0]  DLC_BITS    = 7'h04;
   localparam logic [6:0]  CRC_BITS    = 7'h0f;
   localparam logic [3:0]  MAX_BYTES   = 4'h8;
   localparam logic [14:0] CRC_POLY    = 15'h4599;
   localparam logic [5:0]  CNT_OVF     = 6'h20;
   // Dominant filter thresholds as right shifts of the bit length, and the sample point scale
   localparam int unsigned FILT4_SHIFT  = 3;
   localparam int unsigned FILT10_SHIFT = 4;
   localparam int unsigned SP_SHIFT     = 6;
   // Register offsets
   localparam logic [3:0]  A_FD_CTRL   = 4'h0;
   localparam logic [3:0]  A_CDR1      = 4'h1;
   localparam logic [3:0]  A_CDR2      = 4'h2;
   localparam logic [3:0]  A_QUANTA    = 4'h3;
   localparam logic [3:0]  A_SP        = 4'h4;
   localparam logic [3:0]  A_LIM_HI    = 4'h5;
   localparam logic [3:0]  A_LIM_LO    = 4'h6;
   localparam logic [3:0]  A_STATUS    = 4'h7;
   localparam logic [3:0]  A_BITLEN    = 4'h8;
   // Field positions and reset values
   localparam int unsigned B_FDE       = 0;
   localparam int unsigned B_HOLD      = 1;
   localparam int unsigned B_FILT      = 2;
   localparam int unsigned B_CDR       = 0;
   localparam logic [15:0] RST_QUANTA  = 16'h00fa;
   localparam logic [15:0] RST_LIM_HI  = 16'h0104;
   localparam logic [15:0] RST_LIM_LO  = 16'h00f0;
   localparam logic [5:0]  RST_SP      = 6'h33;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RX   = 3'b010,
      ST_SKIP = 3'b100
   } dec_state_t;
endpackage : swk_fd_pkg

// file: rtl/fd_tolerant_selective_wake_decoder.sv
// Selective wake frame decoder with FD tolerance and clock recovery
`timescale 1ns/100ps
module fd_tolerant_selective_wake_decoder
   import swk_fd_pkg::*;
#(
   parameter int unsigned QW             = 16,
   parameter int unsigned SILENCE_CYCLES = SILENCE_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rd_data_o,
   input  wire logic        rx_i,
   input  wire logic        frame_match_i,
   output logic             wake_o,
   output logic             fd_skip_o
);
   localparam int unsigned SW = $clog2(SILENCE_CYCLES + 1);

   // Quanta must fit the data bus and hold a 1 us bit at full clock
   if (QW > 16 || (1 << QW) <= BIT_MIN_CYC) begin : g_chk
      $error("QW out of range");
   end

   logic             fde, hold, filt, clock_recovery_enable, fde_act, filt_act;
   logic [1:0]       clk_sel;
   logic [5:0]       sp, sp_act, err_cnt;
   logic [QW-1:0]    quanta, lim_hi, lim_lo, bit_len, bit_tmr, last_q;
   logic [QW-1:0]    next_len, dom_run, skip_tmr, thr;
   logic [QW+5:0]    sp_prod;
   logic [2:0]       presc, same_cnt;
   logic [3:0]       idle_cnt, skip_bits, dlc, nbytes;
   logic [6:0]       idx, fdf_idx, dlc_start, crc_end;
   logic [14:0]      crc;
   logic [SW-1:0]    sil_cnt;
   logic [15:0]      rd_word;
   logic             tick, rx_q, edge_fall, sample, rx_smp, last_bit, ide, rtr;
   logic             stuff_bit, stuff_err, fdf_hit, fd_seen, at_delim;
   logic             ok_classic, ok_fd, bad, sof, dom_hit, adj, lim_hit, silence_exp;
   dec_state_t       state;

   function automatic logic [2:0] sel_mask(input logic [1:0] s);
      case (s)
         2'h0:    return 3'h0;
         2'h1:    return 3'h1;
         2'h2:    return 3'h3;
         default: return 3'h7;
      endcase
   endfunction : sel_mask

   function automatic logic [14:0] crc_next(input logic [14:0] c, input logic b);
      return {c[13:0], 1'b0} ^ ((b ^ c[14]) ? CRC_POLY : 15'h0000);
   endfunction : crc_next

   function automatic logic [5:0] cnt_dec(input logic [5:0] c);
      return (c == 6'h00) ? c : c - 6'h01;
   endfunction : cnt_dec

   // Host writes; a write to A_FD_CTRL in the expiry cycle wins over the auto clear
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fde     <= 1'b0;
         hold    <= 1'b0;
         filt    <= 1'b0;
         clock_recovery_enable  <= 1'b0;
         clk_sel <= 2'h0;
         quanta  <= RST_QUANTA[QW-1:0];
         sp      <= RST_SP;
         lim_hi  <= RST_LIM_HI[QW-1:0];
         lim_lo  <= RST_LIM_LO[QW-1:0];
      end else begin
         if (silence_exp) begin
            hold <= 1'b0;
         end
         if (wr_i) begin
            case (addr_i)
               A_FD_CTRL: begin
                  fde  <= wr_data_i[B_FDE];
                  hold <= wr_data_i[B_HOLD];
                  filt <= wr_data_i[B_FILT];
               end
               A_CDR1:   clock_recovery_enable  <= wr_data_i[B_CDR];
               A_CDR2:   clk_sel <= wr_data_i[1:0];
               A_QUANTA: quanta  <= wr_data_i[QW-1:0];
               A_SP:     sp      <= wr_data_i[5:0];
               A_LIM_HI: lim_hi  <= wr_data_i[QW-1:0];
               A_LIM_LO: lim_lo  <= wr_data_i[QW-1:0];
               default: ;
            endcase
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_word = 16'h0000;
      case (addr_i)
         A_FD_CTRL: rd_word[2:0] = {filt, hold, fde};
         A_CDR1:    rd_word[0] = clock_recovery_enable;
         A_CDR2:    rd_word[1:0] = clk_sel;
         A_QUANTA:  rd_word[QW-1:0] = quanta;
         A_SP:      rd_word[5:0] = sp;
         A_LIM_HI:  rd_word[QW-1:0] = lim_hi;
         A_LIM_LO:  rd_word[QW-1:0] = lim_lo;
         A_STATUS:  rd_word[7:0] = {state == ST_SKIP, idle_cnt >= IDLE_BITS, err_cnt};
         A_BITLEN:  rd_word[QW-1:0] = bit_len;
         default: ;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 16'h0000;
      end else begin
         rd_data_o <= rd_i ? rd_word : 16'h0000;
      end
   end

   // Quanta tick from the recovery clock select divider
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         presc <= 3'h0;
         rx_q  <= 1'b1;
      end else begin
         presc <= presc + 3'h1;
         if (tick) begin
            rx_q <= rx_i;
         end
      end
   end

   assign tick      = ((presc | ~sel_mask(clk_sel)) == 3'h7);
   assign edge_fall = tick & rx_q & ~rx_i;
   assign last_q    = bit_len - 1'b1;
   assign sp_prod   = bit_len * sp_act;
   assign sample    = tick && !edge_fall && (bit_tmr == sp_prod[QW+5:SP_SHIFT]);

   // Bit timer; every falling edge hard-syncs, so 1 us bits stay aligned
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_tmr <= '0;
      end else if (edge_fall) begin
         bit_tmr <= '0;
      end else if (tick) begin
         bit_tmr <= (bit_tmr >= last_q) ? '0 : bit_tmr + 1'b1;
      end
   end

   // Late edge stretches the bit, early edge shortens it
   always_comb begin
      next_len = (bit_tmr < (bit_len >> 1)) ? bit_len + 1'b1 : bit_len - 1'b1;
      adj      = clock_recovery_enable && edge_fall && state == ST_RX && bit_tmr != '0;
      lim_hit  = adj && (next_len > lim_hi || next_len < lim_lo);
   end

   // Clock recovery; off, the bit length tracks the programmed quanta
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_len <= RST_QUANTA[QW-1:0];
      end else if (!clock_recovery_enable || lim_hit) begin
         bit_len <= quanta;
      end else if (adj) begin
         bit_len <= next_len;
      end
   end

   // Frame field positions and decoder events
   always_comb begin
      fdf_idx    = ide ? IDX_FDF_E : IDX_FDF_B;
      dlc_start  = fdf_idx + DLC_OFS;
      nbytes     = rtr ? 4'h0 : ((dlc > MAX_BYTES) ? MAX_BYTES : dlc);
      crc_end    = dlc_start + DLC_BITS + {nbytes, 3'b000} + CRC_BITS;
      sof        = state == ST_IDLE && sample && !rx_i && idle_cnt >= IDLE_BITS;
      rx_smp     = state == ST_RX && sample;
      stuff_bit  = idx <= crc_end && same_cnt == STUFF_RUN; // Stuff may follow last CRC bit
      stuff_err  = rx_smp && stuff_bit && rx_i == last_bit;
      fdf_hit    = rx_smp && !stuff_bit && idx == fdf_idx && rx_i;
      fd_seen    = fdf_hit && !fde_act;
      at_delim   = rx_smp && !stuff_bit && idx == crc_end;
      ok_classic = at_delim && rx_i && crc == 15'h0000;
      bad        = stuff_err || (at_delim && !(rx_i && crc == 15'h0000));
      ok_fd      = state == ST_SKIP && skip_bits == EOF_BITS;
      thr        = filt_act ? (bit_len >> FILT10_SHIFT) : (bit_len >> FILT4_SHIFT);
      dom_hit    = !rx_i && dom_run == thr;
   end

   // Decoder state; checks only run in the receive state
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: if (sof) state <= ST_RX;
            ST_RX: begin
               if (fdf_hit && fde_act) begin
                  state <= ST_SKIP;
               end else if (fd_seen || bad || ok_classic) begin
                  state <= ST_IDLE;
               end
            end
            ST_SKIP: if (ok_fd) state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Recessive run before SOF; an FD end leaves the decoder ready
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idle_cnt <= 4'h0;
      end else if (ok_fd) begin
         idle_cnt <= IDLE_BITS;
      end else if (state != ST_IDLE) begin
         idle_cnt <= 4'h0;
      end else if (sample) begin
         idle_cnt <= !rx_i ? 4'h0 : (idle_cnt >= IDLE_BITS) ? idle_cnt : idle_cnt + 4'h1;
      end
   end

   // Destuffing, field capture and CRC; settings latched at SOF
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx      <= 7'h00;
         same_cnt <= 3'h0;
         last_bit <= 1'b1;
         ide      <= 1'b0;
         rtr      <= 1'b0;
         dlc      <= 4'h0;
         crc      <= 15'h0000;
         fde_act  <= 1'b0;
         filt_act <= 1'b0;
         sp_act   <= RST_SP;
      end else if (sof) begin
         idx      <= 7'h01;
         same_cnt <= 3'h1;
         last_bit <= 1'b0;
         ide      <= 1'b0;
         rtr      <= 1'b0;
         dlc      <= 4'h0;
         crc      <= 15'h0000;
         fde_act  <= fde;
         filt_act <= filt;
         sp_act   <= sp;
      end else if (rx_smp) begin
         last_bit <= rx_i;
         if (stuff_bit) begin
            same_cnt <= 3'h1;
         end else begin
            idx      <= idx + 7'h01;
            same_cnt <= (rx_i == last_bit) ? same_cnt + 3'h1 : 3'h1;
            if (idx < crc_end) begin
               crc <= crc_next(crc, rx_i);
            end
            if (idx == IDX_RTR || (ide && idx == IDX_RTR_E)) begin
               rtr <= rx_i;
            end
            if (idx == IDX_IDE) begin
               ide <= rx_i;
            end
            if (idx >= dlc_start && idx < dlc_start + DLC_BITS) begin
               dlc <= {dlc[2:0], rx_i};
            end
         end
      end
   end

   // FD skip: filtered dominant bits restart the end-of-frame count
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dom_run   <= '0;
         skip_tmr  <= '0;
         skip_bits <= 4'h0;
      end else if (state != ST_SKIP) begin
         dom_run   <= '0;
         skip_tmr  <= '0;
         skip_bits <= 4'h0;
      end else if (tick) begin
         dom_run <= (rx_i || &dom_run) ? (rx_i ? '0 : dom_run) : dom_run + 1'b1;
         if (dom_hit) begin
            skip_tmr  <= '0;
            skip_bits <= 4'h0;
         end else if (skip_tmr == last_q) begin
            skip_tmr  <= '0;
            skip_bits <= skip_bits + 4'h1;
         end else begin
            skip_tmr <= skip_tmr + 1'b1;
         end
      end
   end

   // Wake error counter, saturating at overflow
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         err_cnt <= 6'h00;
      end else if (fde && hold) begin
         err_cnt <= 6'h00;
      end else if (!fde) begin
         if ((fd_seen || bad) && err_cnt != CNT_OVF) begin
            err_cnt <= err_cnt + 6'h01;
         end else if (ok_classic) begin
            err_cnt <= cnt_dec(err_cnt);
         end
      end else if (ok_classic || ok_fd) begin
         err_cnt <= cnt_dec(err_cnt);
      end
   end

   // Bus silence timer; expires once per recessive stretch
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sil_cnt <= '0;
      end else if (!rx_i) begin
         sil_cnt <= '0;
      end else if (sil_cnt != SW'(SILENCE_CYCLES)) begin
         sil_cnt <= sil_cnt + 1'b1;
      end
   end
   assign silence_exp = rx_i && sil_cnt == SW'(SILENCE_CYCLES - 1);

   // Wake only on good classic frames, one cycle after the delimiter
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wake_o    <= 1'b0;
         fd_skip_o <= 1'b0;
      end else begin
         wake_o    <= ok_classic && frame_match_i;
         fd_skip_o <= state == ST_SKIP;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   hold_zero_a: assert property (fde && hold |=> err_cnt == 6'h00)
      else $error("counter not held at zero");
   fd_no_wake_a: assert property (state == ST_SKIP |=> !wake_o)
      else $error("wake from an FD frame");
   wake_time_a: assert property (ok_classic && frame_match_i |=> wake_o)
      else $error("wake late");
   fd_enter_a: assert property (fdf_hit && fde_act |=> state == ST_SKIP)
      else $error("FD frame not skipped");
   skip_check_a: assert property (state == ST_SKIP |=> err_cnt <= $past(err_cnt))
      else $error("counter rose while skipping");
   err_inc_a: assert property ((fd_seen || bad) && !fde && err_cnt < CNT_OVF
      |=> err_cnt == $past(err_cnt) + 6'h01)
      else $error("counter did not count up");
   no_inc_a: assert property (fde && !hold |=> err_cnt <= $past(err_cnt))
      else $error("counter rose in tolerant mode");
   sof_idle_a: assert property (sof |-> idle_cnt >= IDLE_BITS && idle_cnt <= 4'ha)
      else $error("SOF too soon");
   eof_ready_a: assert property (ok_fd |=> state == ST_IDLE && idle_cnt == IDLE_BITS)
      else $error("not ready after FD end");
   silence_a: assert property (silence_exp && !wr_i |=> !hold)
      else $error("hold not cleared");
   reload_a: assert property (lim_hit |=> bit_len == $past(quanta))
      else $error("limit did not reload");
   cdr_off_a: assert property (!clock_recovery_enable ##1 !clock_recovery_enable |-> bit_len == $past(quanta))
      else $error("bit length drifts while off");

   good_frame_c: cover property (ok_classic ##1 wake_o);
   fd_frame_c:   cover property (state == ST_SKIP ##[1:1000] ok_fd);
   limit_c:      cover property (lim_hit);
endmodule : fd_tolerant_selective_wake_decoder

// file: test/can_node_model.sv
// Bus node model that drives the receiver line with classic frames and FD frame heads
`timescale 1ns/100ps
module can_node_model
   import swk_fd_pkg::*;
(
   input  wire logic clk_i,
   output logic      rx_o
);
   localparam logic [3:0]  DLC_VAL  = 4'h2;
   localparam logic [15:0] DATA_VAL = 16'hc33c;

   // Hold one level for a number of clock cycles
   task automatic drive(input logic lvl, input int n);
      rx_o <= lvl;
      repeat (n) @(posedge clk_i);
   endtask : drive

   // Kind 0 good, 1 corrupted CRC, 2 FD head only; gap counts recessive bits after delimiter
   task automatic send(input logic [10:0] id, input int kind, input int gap, input int cyc);
      logic        q[$];
      logic [14:0] crc;
      logic        nxt;
      logic        last;
      int          run;
      q = {1'b0};
      for (int i = 10; i >= 0; i--) q.push_back(id[i]);
      q.push_back(1'b0);
      q.push_back(1'b0);
      q.push_back(kind == 2); // Format marker after the base identifier
      if (kind != 2) begin
         q.push_back(1'b0);
         for (int i = 3; i >= 0; i--) q.push_back(DLC_VAL[i]);
         for (int i = 15; i >= 0; i--) q.push_back(DATA_VAL[i]);
         crc = 15'h0000;
         foreach (q[i]) begin
            nxt = q[i] ^ crc[14];
            crc = {crc[13:0], 1'b0};
            if (nxt) crc = crc ^ CRC_POLY;
         end
         // A bad frame flips one CRC bit, nothing else
         if (kind == 1) crc[0] = ~crc[0];
         for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
      end
      // Stuff bit after five equal bits, up to the end of the CRC
      run = 0;
      last = 1'b1;
      foreach (q[i]) begin
         if (run == 5) begin
            drive(~last, cyc);
            last = ~last;
            run = 1;
         end
         drive(q[i], cyc);
         run = (q[i] == last) ? run + 1 : 1;
         last = q[i];
      end
      if (kind != 2) begin
         if (run == 5) drive(~last, cyc);
         drive(1'b1, (1 + gap) * cyc); // Delimiter then gap of recessive bits
      end
   endtask : send
endmodule : can_node_model

// file: test/fd_tolerant_selective_wake_decoder_tb.sv
// Self-checking bench of the FD-tolerant selective wake decoder
`timescale 1ns/100ps
module fd_tolerant_selective_wake_decoder_tb;
   import swk_fd_pkg::*;
   localparam int BIT = 48;
   logic        sys_clk;
   logic        reset_n;
   logic [3:0]  addr;
   logic [15:0] wr_data;
   logic        wr_s;
   logic        rd_s;
   logic [15:0] rd_data;
   logic        rx;
   logic        match;
   logic        wake;
   logic        fd_skip;
   logic [15:0] got;
   int          num_errors = 0;
   int          compares = 0;
   int          wakes = 0;
   int          wtab [4] = '{2, 9, 1, 5};
   logic [15:0] rst_tab [9] = '{16'h0000, 16'h0000, 16'h0000, RST_QUANTA,
      {10'h000, RST_SP}, RST_LIM_HI, RST_LIM_LO, 16'h0000, RST_QUANTA};

   fd_tolerant_selective_wake_decoder #(.SILENCE_CYCLES(2000)) DUT (
      .sys_clk_i     (sys_clk),
      .reset_n_i     (reset_n),
      .addr_i        (addr),
      .wr_data_i     (wr_data),
      .wr_i          (wr_s),
      .rd_i          (rd_s),
      .rd_data_o     (rd_data),
      .rx_i          (rx),
      .frame_match_i (match),
      .wake_o        (wake),
      .fd_skip_o     (fd_skip)
   );
   can_node_model u_node (
      .clk_i (sys_clk),
      .rx_o  (rx)
   );

   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Wake pulses are one cycle long, so count every one
   always @(posedge sys_clk) begin
      if (wake === 1'b1) wakes <= wakes + 1;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wr_data <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
      // Gap cycle: strobe never driven twice in one step, and effects settle two edges on
      @(posedge sys_clk);
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      @(negedge sys_clk);
      d = rd_data;
      @(posedge sys_clk);
   endtask : rd
   task automatic check_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      compares++;
      if ((v & m) !== e) begin
         num_errors++;
         $display("[FAIL] %0t reg %0h read %h expected %h", $time, a, v, e);
      end
   endtask : check_reg
   task automatic check_flag(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : check_flag
   // One frame, then wake count and error counter
   task automatic frame(input int kind, input int gap, input logic m, input int cyc,
                        input int ew, input logic [5:0] ec);
      int w0;
      match <= m;
      w0 = wakes;
      u_node.send(11'h5a3, kind, gap, cyc);
      check_flag(wakes - w0 == ew, "wake count");
      check_reg(A_STATUS, 16'h003f, {10'h000, ec});
   endtask : frame
   // FD head, one dominant pulse of w cycles in the fast phase, then silence
   task automatic fd_frame(input int w, input logic es, input logic [5:0] ec);
      int w0;
      match <= 1'b1;
      w0 = wakes;
      u_node.send(11'h0f1, 2, 0, BIT);
      u_node.drive(1'b1, 4 * BIT);
      u_node.drive(1'b0, w);
      u_node.drive(1'b1, 6 * BIT);
      check_flag(fd_skip === es, "skip level after pulse");
      u_node.drive(1'b1, 12 * BIT);
      check_flag(fd_skip === 1'b0, "skip not ended");
      check_flag(wakes == w0, "wake on FD frame");
      check_reg(A_STATUS, 16'h003f, {10'h000, ec});
   endtask : fd_frame
   task automatic complete_run();
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // Watchdog well above the expected run length
   initial begin
      repeat (95000) @(posedge sys_clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      reset_n = 1'b0;
      addr = 4'h0;
      wr_data = 16'h0000;
      wr_s = 1'b0;
      rd_s = 1'b0;
      match = 1'b0;
      u_node.drive(1'b1, 0); // Idle bus is recessive through the termination
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      // Reset values, read-only and unmapped places
      for (int a = 0; a < 9; a++) check_reg(a[3:0], (a == 7) ? 16'h003f : 16'hffff, rst_tab[a]);
      wr(A_STATUS, 16'hffff);
      wr(4'h9, 16'hffff);
      check_reg(A_STATUS, 16'h003f, 16'h0000);
      check_reg(4'h9, 16'hffff, 16'h0000);
      wr(A_QUANTA, 16'h0030);
      u_node.drive(1'b1, 10 * BIT);
      // Tolerance off: up on bad and FD frames, down on good ones
      frame(1, 12, 1'b1, BIT, 0, 6'h01);
      fd_frame(9, 1'b0, 6'h02);
      frame(0, 12, 1'b1, BIT, 1, 6'h01);
      // Idle run before start-of-frame: 5 bits too few, 10 bits enough
      frame(1, 5, 1'b1, BIT, 0, 6'h02);
      frame(0, 12, 1'b1, BIT, 0, 6'h02);
      frame(1, 10, 1'b1, BIT, 0, 6'h03);
      frame(0, 12, 1'b1, BIT, 1, 6'h02);
      frame(0, 12, 1'b0, BIT, 0, 6'h01);
      // Tolerance on, hold off
      wr(A_FD_CTRL, 16'h0001);
      frame(1, 12, 1'b1, BIT, 0, 6'h01);
      fd_frame(9, 1'b1, 6'h00);
      frame(0, 12, 1'b1, BIT, 1, 6'h00);
      // Both filter settings, one pulse ignored and one counted each
      for (int f = 0; f < 2; f++) begin
         wr(A_FD_CTRL, 16'h0001 | (16'(f) << B_FILT));
         fd_frame(wtab[2 * f], 1'b0, 6'h00);
         fd_frame(wtab[2 * f + 1], 1'b1, 6'h00);
      end
      // Hold with tolerance keeps the counter at zero until silence clears it
      wr(A_FD_CTRL, 16'h0000);
      frame(1, 12, 1'b1, BIT, 0, 6'h01);
      wr(A_FD_CTRL, 16'h0003);
      check_reg(A_STATUS, 16'h003f, 16'h0000);
      frame(1, 12, 1'b1, BIT, 0, 6'h00);
      repeat (2100) @(posedge sys_clk);
      check_reg(A_FD_CTRL, 16'h0007, 16'h0001);
      // Recovery setup order: off, clock select, quanta and limits, then on
      wr(A_CDR1, 16'h0000);
      wr(A_CDR2, 16'h0000);
      wr(A_QUANTA, 16'h0030);
      wr(A_LIM_HI, 16'h0050);
      wr(A_LIM_LO, 16'h0028);
      wr(A_CDR1, 16'h0001);
      frame(0, 12, 1'b1, 45, 1, 6'h00);
      rd(A_BITLEN, got);
      check_flag(got < 16'h0030, "bit length not tracking");
      // Narrow limits force reloads of the programmed quanta
      wr(A_CDR1, 16'h0000);
      wr(A_LIM_HI, 16'h0030);
      wr(A_LIM_LO, 16'h0030);
      wr(A_CDR1, 16'h0001);
      frame(0, 12, 1'b1, BIT, 1, 6'h00);
      rd(A_BITLEN, got);
      check_flag(got === 16'h0030, "bit length not reloaded");
      // Slower quanta tick with half the quanta gives the same bit time
      wr(A_CDR1, 16'h0000);
      wr(A_CDR2, 16'h0001);
      wr(A_QUANTA, 16'h0018);
      check_reg(A_BITLEN, 16'hffff, 16'h0018);
      frame(0, 12, 1'b1, BIT, 1, 6'h00);
      complete_run();
   end
endmodule : fd_tolerant_selective_wake_decoder_tb
